// [dpc_pkg.sv]
// Purpose: shared constants for display presentation control
// Assumes: 125 MHz system clock, 0.1 s coarse tick
// Notes:   settings arrive as plain ports from the menu logic
`default_nettype none
package dpc_pkg;
    localparam int          CLK_HZ          = 125000000;      // system clock rate
    localparam int          TICK_MS         = 100;            // tick period in ms
    localparam int          TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS; // cycles per tick
    localparam logic [6:0]  FILT_MIN        = 7'h01;          // 0.1 s in tenths
    localparam logic [6:0]  FILT_MAX        = 7'h64;          // 10.0 s in tenths
    localparam logic [6:0]  FILT_RESET      = 7'h01;          // default 0.1 s
    localparam logic [13:0] BLANK_MIN       = 14'h000a;       // 10 s
    localparam logic [13:0] BLANK_MAX       = 14'h270f;       // 9999 s
    localparam logic [13:0] BLANK_OFF       = 14'h0000;       // blanking off
    localparam logic [3:0]  TICKS_PER_SEC   = 4'ha;           // ten ticks a second
    localparam logic [1:0]  FRAC_MAX        = 2'h3;           // most fraction digits
    localparam logic [1:0]  FRAC_RESET      = 2'h0;           // default digits
    typedef enum logic [1:0] {DPC_UNIT_F, DPC_UNIT_C, DPC_UNIT_K} dpc_unit_t;
    typedef enum logic [1:0] {DPC_IN_RTD, DPC_IN_TC, DPC_IN_LINEAR} dpc_input_t;
endpackage
`default_nettype wire

// [dpc_display_control.sv]
// Purpose: rate-limits shown process value, blanks target value, applies units/digits
// Assumes: settings and values synchronous to clk; clk_en freezes all state
// Notes:   values are signed integers in hundredths-free raw counts (scaled by 10^digits)
// Operation
// [RULE_01] shown value changes at most once per interval
// [RULE_02] filter never touches control-path value
// [RULE_03] interval in tenths regardless of digits
// [RULE_04] units Fahrenheit, Celsius, Kelvin; Fahrenheit default
// [RULE_05] unit used internally and on comms
// [RULE_06] unit setting offered only for RTD/thermocouple
// [RULE_07] blank target value after configured seconds
// [RULE_08] any key restores blanked target value
// [RULE_09] restored value blanks again after period
// [RULE_10] linear digits 0..3, default 0
// [RULE_11] nonzero digits force fraction, narrow range
// [RULE_12] digits set stored fraction for values
// [RULE_13] timers use 0.1 s tick; off means visible
`timescale 1ns/1ns
`default_nettype none
module dpc_display_control #(
    parameter int TICK_CYCLES = dpc_pkg::TICK_CYCLES, // shorten for simulation
    parameter int VW          = 20                    // value width
) (
    input  wire logic          clk,
    input  wire logic          srst,
    input  wire logic          clk_en,
    input  wire logic [1:0]    input_type,        // dpc_input_t code
    input  wire logic          cfg_load,          // menu applies settings
    input  wire logic [6:0]    pv_display_min_interval, // tenths of seconds
    input  wire logic [13:0]   setpoint_blank_time,     // seconds, 0 = off
    input  wire logic [1:0]    fraction_digit_count,
    input  wire logic [1:0]    unit_select,       // dpc_unit_t code
    input  wire logic          key_press,         // any key pulse
    input  wire logic signed [VW-1:0] process_value,   // measured, full precision x1000
    input  wire logic signed [VW-1:0] target_value,    // setpoint, full precision x1000
    output logic signed [VW-1:0] pv_shown,        // value to display
    output logic signed [VW-1:0] pv_control,      // value for control path
    output logic signed [VW-1:0] sv_stored,       // setpoint at stored digits
    output logic               sv_visible,        // setpoint shown when high
    output logic [1:0]         unit_active,       // unit used inside and on comms
    output logic [1:0]         digits_active,     // stored fraction digits
    output logic               unit_menu_offered  // unit item shown in menu
);
    localparam int TW = $clog2(TICK_CYCLES + 1);  // tick counter width

    typedef struct packed {
        logic [TW-1:0]        tick_cnt;   // divider toward 0.1 s
        logic [6:0]           filt_cfg;   // interval in tenths
        logic [13:0]          blank_cfg;  // blank seconds
        logic [1:0]           digits;     // fraction digits
        logic [1:0]           unit;       // temperature unit
        logic [6:0]           filt_cnt;   // tenths since last update
        logic [3:0]           sub_sec;    // tenths within a second
        logic [13:0]          blank_cnt;  // seconds shown
        logic                 visible;    // setpoint shown
        logic signed [VW-1:0] pv_shown;
        logic signed [VW-1:0] pv_ctl;
        logic signed [VW-1:0] sv;
        logic                 offered;
    } dpc_state_t;

    dpc_state_t st;       // registered state
    dpc_state_t next_st;  // next state

    // drop fraction digits from a x1000 value to the chosen count
    function automatic logic signed [VW-1:0] scale(input logic signed [VW-1:0] v,
                                                    input logic [1:0] d);
        case (d)
            2'h0:    scale = VW'(v / 1000);
            2'h1:    scale = VW'(v / 100);
            2'h2:    scale = VW'(v / 10);
            default: scale = v;
        endcase
    endfunction

    wire logic temp_in = (input_type == 2'(dpc_pkg::DPC_IN_RTD))
                      || (input_type == 2'(dpc_pkg::DPC_IN_TC));
    wire logic tick    = (st.tick_cnt == TW'(TICK_CYCLES - 1));

    // next-state logic
    always_comb begin
        next_st = st;
        next_st.offered = temp_in; // RULE_06
        next_st.tick_cnt = tick ? '0 : st.tick_cnt + TW'(1); // RULE_13
        if (cfg_load) begin
            // interval held in tenths, independent of digits
            if (pv_display_min_interval >= dpc_pkg::FILT_MIN
                && pv_display_min_interval <= dpc_pkg::FILT_MAX) begin
                next_st.filt_cfg = pv_display_min_interval; // RULE_03
            end
            if (setpoint_blank_time == dpc_pkg::BLANK_OFF
                || (setpoint_blank_time >= dpc_pkg::BLANK_MIN
                    && setpoint_blank_time <= dpc_pkg::BLANK_MAX)) begin
                next_st.blank_cfg = setpoint_blank_time; // RULE_07
                next_st.blank_cnt = '0;
                next_st.sub_sec   = '0;
            end
            // full digit range only selectable for linear; temperature caps at 1
            if (!temp_in || fraction_digit_count <= 2'h1) begin
                next_st.digits = fraction_digit_count; // RULE_10
            end
            if (temp_in && unit_select <= 2'(dpc_pkg::DPC_UNIT_K)) begin
                next_st.unit = unit_select; // RULE_04 RULE_06
            end
        end
        // stored values carry the chosen digit count
        next_st.pv_ctl = scale(process_value, st.digits); // RULE_02 RULE_12
        next_st.sv     = scale(target_value, st.digits); // RULE_11 RULE_12
        // display rate limit
        if (tick) begin
            if (st.filt_cnt + 7'h01 >= st.filt_cfg) begin
                next_st.filt_cnt = '0;
                next_st.pv_shown = scale(process_value, st.digits); // RULE_01
            end else begin
                next_st.filt_cnt = st.filt_cnt + 7'h01;
            end
        end
        // setpoint blanking
        if (st.blank_cfg == dpc_pkg::BLANK_OFF) begin
            next_st.visible = 1'b1; // RULE_13
        end else if (key_press) begin
            next_st.visible   = 1'b1; // RULE_08
            next_st.blank_cnt = '0;   // RULE_09
            next_st.sub_sec   = '0;
        end else if (st.visible && tick) begin
            if (st.sub_sec == dpc_pkg::TICKS_PER_SEC - 4'h1) begin
                next_st.sub_sec = '0;
                if (st.blank_cnt + 14'h0001 >= st.blank_cfg) begin
                    next_st.visible = 1'b0; // RULE_07 RULE_09
                end else begin
                    next_st.blank_cnt = st.blank_cnt + 14'h0001;
                end
            end else begin
                next_st.sub_sec = st.sub_sec + 4'h1;
            end
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (srst) begin
            st           <= '0;
            st.filt_cfg  <= dpc_pkg::FILT_RESET;
            st.blank_cfg <= dpc_pkg::BLANK_OFF;
            st.digits    <= dpc_pkg::FRAC_RESET;
            st.unit      <= 2'(dpc_pkg::DPC_UNIT_F); // RULE_04
            st.visible   <= 1'b1;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign pv_shown          = st.pv_shown;
    assign pv_control        = st.pv_ctl;
    assign sv_stored         = st.sv;
    assign sv_visible        = st.visible;
    assign unit_active       = st.unit; // RULE_05
    assign digits_active     = st.digits;
    assign unit_menu_offered = st.offered;

    // shown value only moves on an interval boundary
    chk_pv_rate_limit: assert property (@(posedge clk) disable iff (srst) // RULE_01
        !$past(srst) && $changed(st.pv_shown)
        |-> $past(clk_en) && $past(tick)
            && $past(st.filt_cnt) + 7'h01 >= $past(st.filt_cfg))
        else $error("shown value changed before interval");
    // control copy follows the input one edge later, unfiltered
    chk_ctl_follows: assert property (@(posedge clk) disable iff (srst) // RULE_02
        clk_en && $past(clk_en) && !$past(srst)
        |-> pv_control == scale($past(process_value), $past(st.digits)))
        else $error("control value not tracking input");
    // any key shows the setpoint on the next edge
    chk_key_restore: assert property (@(posedge clk) disable iff (srst) // RULE_08
        clk_en && key_press |=> sv_visible)
        else $error("key did not restore setpoint");
    // blanking off brings the setpoint back one edge after it is in force
    chk_off_visible: assert property (@(posedge clk) disable iff (srst) // RULE_13
        clk_en && st.blank_cfg == dpc_pkg::BLANK_OFF |=> sv_visible)
        else $error("setpoint hidden while blanking off");
    // stored blank time is off or inside its range
    chk_blank_range: assert property (@(posedge clk) disable iff (srst) // RULE_07
        st.blank_cfg == 14'h0000 || (st.blank_cfg >= 14'h000a && st.blank_cfg <= 14'h270f))
        else $error("blank time out of range");
    // stored interval stays inside the tenths range
    chk_filt_range: assert property (@(posedge clk) disable iff (srst) // RULE_03
        st.filt_cfg >= 7'h01 && st.filt_cfg <= 7'h64)
        else $error("filter interval out of range");
    // unit code never leaves the three choices
    chk_unit_legal: assert property (@(posedge clk) disable iff (srst) // RULE_04
        unit_active <= 2'h2)
        else $error("illegal unit");
    // a load on a linear input leaves the unit alone
    chk_unit_gate: assert property (@(posedge clk) disable iff (srst) // RULE_06
        clk_en && cfg_load && !temp_in |=> $stable(unit_active))
        else $error("unit changed on linear input");
    // setpoint comes back only through a key or blanking turned off
    chk_blank_after: assert property (@(posedge clk) disable iff (srst) // RULE_08
        !$past(srst) && sv_visible && !$past(sv_visible)
        |-> $past(st.blank_cfg) == dpc_pkg::BLANK_OFF || $past(key_press))
        else $error("setpoint restored without a key");
    // stored setpoint carries the digits in force one edge earlier
    chk_digits_store: assert property (@(posedge clk) disable iff (srst) // RULE_12
        clk_en && $past(clk_en) && !$past(srst)
        |-> sv_stored == scale($past(target_value), $past(st.digits)))
        else $error("stored setpoint digits wrong");
    // a key restarts the blanking period from zero
    chk_blank_restart: assert property (@(posedge clk) disable iff (srst) // RULE_09
        clk_en && key_press && st.blank_cfg != dpc_pkg::BLANK_OFF
        |=> st.blank_cnt == 14'h0000 && st.sub_sec == 4'h0)
        else $error("blank period not restarted by key");
    // blanking falls only at a second boundary once the period is used up
    chk_blank_expiry: assert property (@(posedge clk) disable iff (srst) // RULE_07
        $fell(sv_visible)
        |-> $past(st.blank_cfg) != dpc_pkg::BLANK_OFF
            && $past(st.sub_sec) == dpc_pkg::TICKS_PER_SEC - 4'h1
            && $past(st.blank_cnt) + 14'h0001 >= $past(st.blank_cfg))
        else $error("setpoint blanked before period ended");
    // unit menu item follows the input type one edge later
    chk_unit_offer: assert property (@(posedge clk) disable iff (srst) // RULE_06
        clk_en |=> unit_menu_offered == $past(temp_in))
        else $error("unit item offer wrong");
    // temperature inputs refuse more than one fraction digit
    chk_digits_cap: assert property (@(posedge clk) disable iff (srst) // RULE_10
        clk_en && cfg_load && temp_in && fraction_digit_count > 2'h1
        |=> $stable(digits_active))
        else $error("digits above one on temperature input");
endmodule
`default_nettype wire

// [dpc_panel_model.sv]
// Purpose: keypad and front panel stand-in for display presentation control
// Assumes: press_req is driven away from the rising edge
// Notes:   records the fewest cycles between changes of the shown value
`timescale 1ns/1ns
`default_nettype none
module dpc_panel_model #(parameter int VW = 20) (
    input  wire logic                 clk,
    input  wire logic                 clear,     // restart the gap statistics
    input  wire logic                 press_req, // bench asks for a key press
    input  wire logic signed [VW-1:0] pv_shown,
    output logic                      key_press, // one pulse per request
    output int                        min_gap,   // fewest cycles between changes
    output int                        changes    // shown value updates seen
);
    int                   gap;  // cycles since the last change
    logic signed [VW-1:0] last; // shown value one edge ago
    // key pulse leaves just after the edge; gap statistics follow the display
    always @(posedge clk) begin
        key_press <= press_req;
        gap = gap + 1;
        if (clear) begin
            changes = 0;
            min_gap = 1000000;
            gap = 0;
        end else if (pv_shown !== last) begin
            if (changes > 0 && gap < min_gap) min_gap = gap;
            changes = changes + 1;
            gap = 0;
        end
        last = pv_shown;
    end
endmodule
`default_nettype wire

// [display_presentation_control_test.sv]
// Purpose: self-checking bench for display presentation control
// Assumes: tick shortened to 10 cycles; inputs change on the falling edge
// Notes:   a 10 s blank period is 1000 cycles at this tick
`timescale 1ns/1ns
`default_nettype none
module display_presentation_control_test;
    localparam int TC = 10; // cycles per tick in simulation
    logic clk, srst, cfg_load, key_press, press_req, clear, sv_visible, unit_menu_offered;
    logic               clk_en; // freezes the design while low
    logic        [1:0]  input_type, fraction_digit_count, unit_select, unit_active, digits_active;
    logic        [6:0]  pv_display_min_interval;
    logic        [13:0] setpoint_blank_time;
    logic signed [19:0] process_value, target_value, pv_shown, pv_control, sv_stored;
    int                 bad_count, checked, min_gap, changes, cyc;
    dpc_display_control #(.TICK_CYCLES(TC)) i_dpc_display_control (.clk, .srst, .clk_en,
        .input_type, .cfg_load, .pv_display_min_interval, .setpoint_blank_time,
        .fraction_digit_count, .unit_select, .key_press, .process_value, .target_value,
        .pv_shown, .pv_control, .sv_stored, .sv_visible, .unit_active, .digits_active,
        .unit_menu_offered);
    dpc_panel_model i_dpc_panel_model (.clk, .clear, .press_req, .pv_shown, .key_press,
        .min_gap, .changes);
    // compare one value and count it
    task automatic check(input string what, input logic signed [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one-cycle settings load, then let the new settings land
    task automatic apply();
        cfg_load = 1;
        step(1);
        cfg_load = 0;
        step(1);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    // hang guard well beyond the planned 3500 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    initial begin
        {srst, clear} = 2'h3;
        {cfg_load, press_req, input_type, unit_select, fraction_digit_count} = 0;
        clk_en = 1;
        pv_display_min_interval = 7'h01;
        setpoint_blank_time = 14'h0000;
        process_value = 0;
        target_value = 0;
        step(4);
        srst = 0;
        step(1);
        check("unit reset", unit_active, 0);
        check("digits reset", digits_active, 0);
        check("visible reset", sv_visible, 1);
        check("unit menu rtd", unit_menu_offered, 1);
        // every unit, alternating RTD and thermocouple inputs; two digits refused
        fraction_digit_count = 2'h2;
        for (int u = 0; u < 3; u++) begin
            input_type = 2'(u % 2);
            unit_select = 2'(u);
            apply();
            check("unit", unit_active, u);
        end
        check("digits temp capped", digits_active, 0);
        input_type = 2'h2;
        unit_select = 2'h1;
        apply();
        check("unit linear kept", unit_active, 2);
        check("unit menu linear", unit_menu_offered, 0);
        process_value = 20'sd12345;
        target_value = 20'sd12345;
        for (int d = 0; d < 4; d++) begin
            fraction_digit_count = 2'(d);
            apply();
            step(2);
            check("digits", digits_active, d);
            check("stored setpoint", sv_stored, 12345 / 10 ** (3 - d));
        end
        // value moves every cycle; display may follow only every 5 ticks
        pv_display_min_interval = 7'h05;
        apply();
        clear = 0;
        repeat (300) begin
            process_value = process_value + 20'sd1;
            step(1);
        end
        step(3);
        check("control value", pv_control, process_value);
        check("filter gap ok", min_gap >= 5 * TC, 1);
        check("filter updates", changes >= 4, 1);
        // clock enable low freezes the control copy
        clk_en = 0;
        process_value = process_value + 20'sd100;
        step(20);
        check("frozen control", pv_control, process_value - 100);
        clk_en = 1;
        step(3);
        check("control resumes", pv_control, process_value);
        setpoint_blank_time = 14'h000a;
        apply();
        step(975);
        check("visible before", sv_visible, 1);
        step(45);
        check("blanked", sv_visible, 0);
        press_req = 1;
        step(1);
        press_req = 0;
        step(2);
        check("key restores", sv_visible, 1);
        step(973);
        check("still visible", sv_visible, 1);
        step(45);
        check("blanked again", sv_visible, 0);
        setpoint_blank_time = 14'h0000;
        apply();
        step(1100);
        check("blank off", sv_visible, 1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
